// [core/sysref_req_pkg.sv]
// package: register map, field layouts, timing constants for request logic
package sysref_req_pkg;
  // ****************************************
  // register offsets (byte addresses)
  // ****************************************
  localparam logic [7:0] ctrl_off = 8'h00;
  localparam logic [7:0] delay_off = 8'h04;
  localparam logic [7:0] status_off = 8'h08;
  localparam logic [7:0] reset_off = 8'h0C;
  localparam logic [7:0] current_off = 8'h10;
  // ****************************************
  // ctrl fields
  // ****************************************
  localparam int func_lsb = 0;
  localparam int input_sel_lsb = 2;
  localparam int sync_cmd_bit = 4;
  // ****************************************
  // delay fields
  // ****************************************
  localparam int dly_count_lsb = 0;
  localparam int dly_count_w = 7;
  localparam int dly_step_lsb = 8;
  // ****************************************
  // reset values, plus the final current setting
  // ****************************************
  localparam logic [1:0] func_rst = 2'h1;
  localparam logic [1:0] input_sel_rst = 2'h0;
  localparam logic [6:0] dly_count_rst = 7'h00;
  localparam logic [1:0] dly_step_rst = 2'h0;
  localparam logic [3:0] current_rst = 4'h0;
  localparam logic [3:0] current_final = 4'h6;
  // ****************************************
  // encodings
  // ****************************************
  typedef enum logic [1:0] {
    func_sync = 2'h0,
    func_request = 2'h1,
    func_window = 2'h2
  } req_func_t;
  localparam logic [1:0] sel_pin = 2'h0;
  localparam logic [1:0] sel_low = 2'h2;
  localparam logic [1:0] sel_high = 2'h3;
  // step sizes in femtoseconds, codes 0..3
  localparam int step_fs_0 = 22250;
  localparam int step_fs_1 = 13000;
  localparam int step_fs_2 = 10500;
  localparam int step_fs_3 = 7750;
  // ****************************************
  // timing
  // ****************************************
  localparam int clk_period_ps = 20000;
  localparam int hold_extra_ps = 1600;
  localparam int hold_clk_periods = 3;
  // least time rounds up
  localparam int hold_extra_cyc =
    (hold_extra_ps + clk_period_ps - 1) / clk_period_ps;
  localparam int valid_hold_cyc = hold_clk_periods + hold_extra_cyc;
  localparam int soft_reset_ns = 1000;
  localparam int soft_reset_cyc = (soft_reset_ns * 1000 + clk_period_ps - 1)
    / clk_period_ps;
  localparam int sync_spacing_cyc = 75;
  localparam int sync_high_cyc = 6;
endpackage

// [core/sysref_request_window_sync.sv]
// module: request pin windowing, delay, sync and reset control with apb
//
// The placing of the registers and register access over APB were decided locally.
module sysref_request_window_sync #(
  parameter int soft_reset_cycles = sysref_req_pkg::soft_reset_cyc
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // request pin and input clock edge sample
  input wire logic request_input_pin,
  input wire logic input_clock_pin,
  // outputs to the clock path
  output logic request_internal,
  output logic frame_request,
  output logic divider_sync,
  output logic soft_reset_active,
  output logic [31:0] request_delay_fs
);
  // ****************************************
  // registers
  // ****************************************
  logic [1:0] func_reg;
  logic [1:0] input_sel_reg;
  logic [6:0] dly_count_reg;
  logic [1:0] dly_step_reg;
  logic reset_bit_reg;
  logic [3:0] current_reg;
  logic [31:0] prdata_reg;
  logic pready_reg;
  logic pslverr_reg;
  logic [2:0] pin_hist_reg;
  logic [2:0] hold_cnt_reg;
  logic [1:0] edge_pos_reg;
  logic pos_valid_reg;
  logic [2:0] pos_sync1_reg;
  logic [2:0] pos_sync2_reg;
  logic [6:0] dly_cnt_reg;
  logic [7:0] gap_cnt_reg;
  logic sync_reg;
  logic [15:0] rst_cnt_reg;
  logic rst_ok_reg;
  logic reqi_reg;
  logic freq_reg;
  logic srst_reg;
  logic [31:0] dly_fs_reg;
  // ****************************************
  // decode
  // ****************************************
  function automatic int step_fs(input logic [1:0] code);
    case (code)
      2'h0: step_fs = sysref_req_pkg::step_fs_0;
      2'h1: step_fs = sysref_req_pkg::step_fs_1;
      2'h2: step_fs = sysref_req_pkg::step_fs_2;
      default: step_fs = sysref_req_pkg::step_fs_3;
    endcase
  endfunction
  wire setup_w = psel && !penable;
  wire wr_en = psel && penable && pwrite && pready_reg;
  wire hit_ctrl = paddr == sysref_req_pkg::ctrl_off;
  wire hit_dly = paddr == sysref_req_pkg::delay_off;
  wire hit_stat = paddr == sysref_req_pkg::status_off;
  wire hit_rst = paddr == sysref_req_pkg::reset_off;
  wire hit_cur = paddr == sysref_req_pkg::current_off;
  wire mapped = hit_ctrl | hit_dly | hit_stat | hit_rst | hit_cur;
  wire sync_cmd = wr_en && hit_ctrl && pwdata[sysref_req_pkg::sync_cmd_bit];
  wire sel_level = (input_sel_reg == sysref_req_pkg::sel_high) ? 1'b1 :
    (input_sel_reg == sysref_req_pkg::sel_low) ? 1'b0 : request_input_pin;
  wire pin_rise = pin_hist_reg[0] && !pin_hist_reg[1];
  // windowing looks at the raw pin, never the delayed copy
  wire win_mode = func_reg == sysref_req_pkg::func_window;
  wire sync_mode = func_reg == sysref_req_pkg::func_sync;
  wire req_mode = func_reg == sysref_req_pkg::func_request;
  wire sel_rise = sel_level && !pin_hist_reg[2];
  // spacing only a hazard guard; too-close edges are ignored
  wire pin_sync = sync_mode && sel_rise &&
    (gap_cnt_reg == 8'h00);
  wire [31:0] dly_fs_next =
    32'(step_fs(dly_step_reg)) * 32'(dly_count_reg);
  wire [31:0] rdata_next =
    hit_ctrl ? {28'h0000000, input_sel_reg, func_reg} :
    hit_dly ? {22'h000000, dly_step_reg, 1'b0, dly_count_reg} :
    hit_stat ? {29'h00000000, pos_sync2_reg} :
    hit_rst ? {31'h00000000, reset_bit_reg} :
    hit_cur ? {28'h0000000, current_reg} : 32'h00000000;
  // ****************************************
  // apb
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= setup_w;
      prdata_reg <= setup_w ? rdata_next : prdata_reg;
      pslverr_reg <= setup_w && !mapped;
    end
  end
  always_ff @(posedge mclk) begin
    if (!reset_n || srst_reg) begin
      func_reg <= sysref_req_pkg::func_rst;
      input_sel_reg <= sysref_req_pkg::input_sel_rst;
      dly_count_reg <= sysref_req_pkg::dly_count_rst;
      dly_step_reg <= sysref_req_pkg::dly_step_rst;
      current_reg <= sysref_req_pkg::current_rst;
    end else if (wr_en) begin
      if (hit_ctrl) begin
        func_reg <= pwdata[1:0];
        input_sel_reg <= pwdata[3:2];
      end
      if (hit_dly) begin
        dly_count_reg <= pwdata[6:0];
        dly_step_reg <= pwdata[9:8];
      end
      if (hit_cur) current_reg <= pwdata[3:0];
    end
  end
  // ****************************************
  // software reset
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      reset_bit_reg <= 1'b0;
      rst_cnt_reg <= 16'h0000;
      rst_ok_reg <= 1'b0;
      srst_reg <= 1'b0;
    end else begin
      srst_reg <= 1'b0;
      if (wr_en && hit_rst) reset_bit_reg <= pwdata[0];
      if (wr_en && hit_rst && pwdata[0] && !reset_bit_reg) begin
        rst_cnt_reg <= 16'h0000;
        rst_ok_reg <= 1'b0;
      end else if (reset_bit_reg && !rst_ok_reg) begin
        rst_cnt_reg <= rst_cnt_reg + 16'h0001;
        rst_ok_reg <= rst_cnt_reg >= 16'(soft_reset_cycles - 1);
      end
      // a clear too early is a short pulse: ignored
      if (wr_en && hit_rst && !pwdata[0] && reset_bit_reg && rst_ok_reg)
        srst_reg <= 1'b1;
    end
  end
  // ****************************************
  // windowing
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_hist_reg <= 3'h0;
      hold_cnt_reg <= 3'h0;
      edge_pos_reg <= 2'h0;
      pos_valid_reg <= 1'b0;
      pos_sync1_reg <= 3'h0;
      pos_sync2_reg <= 3'h0;
    end else begin
      pin_hist_reg <= {sel_level, pin_hist_reg[0], request_input_pin};
      if (win_mode && pin_rise) begin
        edge_pos_reg <= {input_clock_pin, 1'b1};
        hold_cnt_reg <= 3'h1;
        pos_valid_reg <= 1'b0;
      end else if (win_mode && pin_hist_reg[0] &&
          hold_cnt_reg != 3'h0) begin
        if (hold_cnt_reg >= 3'(sysref_req_pkg::valid_hold_cyc)) begin
          pos_valid_reg <= 1'b1;
          hold_cnt_reg <= 3'h0;
        end else hold_cnt_reg <= hold_cnt_reg + 3'h1;
      end else if (!pin_hist_reg[0]) hold_cnt_reg <= 3'h0;
      pos_sync1_reg <= {pos_valid_reg, edge_pos_reg};
      pos_sync2_reg <= pos_sync1_reg;
    end
  end
  // ****************************************
  // delay, sync, outputs
  // ****************************************
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      dly_cnt_reg <= 7'h00;
      gap_cnt_reg <= 8'h00;
      sync_reg <= 1'b0;
      reqi_reg <= 1'b0;
      freq_reg <= 1'b0;
      dly_fs_reg <= 32'h00000000;
    end else begin
      dly_fs_reg <= dly_fs_next;
      reqi_reg <= sel_level;
      freq_reg <= req_mode && sel_level;
      if (pin_sync)
        gap_cnt_reg <= 8'(sysref_req_pkg::sync_spacing_cyc - 1);
      else if (gap_cnt_reg != 8'h00) gap_cnt_reg <= gap_cnt_reg - 8'h01;
      // one pulse realigns all seven dividers together
      sync_reg <= pin_sync || sync_cmd;
    end
  end
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign request_internal = reqi_reg;
  assign frame_request = freq_reg;
  assign divider_sync = sync_reg;
  assign soft_reset_active = srst_reg;
  assign request_delay_fs = dly_fs_reg;
endmodule

// [tb/sysref_req_checker.sv]
// checker: apb and output timing properties of the request block
module sysref_req_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // watched ports
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic divider_sync,
  input wire logic soft_reset_active
);
  timeunit 1ns / 1ns;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!reset_n);
  // cycles since last sync, saturating so a count never wraps
  logic [6:0] gap_reg;
  always_ff @(posedge mclk) begin
    if (!reset_n) gap_reg <= 7'h4B;
    else if (divider_sync) gap_reg <= 7'h00;
    else if (gap_reg != 7'h4B) gap_reg <= gap_reg + 7'h01;
  end
  property p_rdy; psel && !penable |=> pready; endproperty
  a_rdy: assert property (p_rdy) else $error("ready late");
  property p_acc; pready |-> psel && penable; endproperty
  a_acc: assert property (p_acc) else $error("ready outside access");
  property p_one; pready |=> !pready; endproperty
  a_one: assert property (p_one) else $error("ready too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_erd; pslverr && !pwrite |-> prdata == 32'h0; endproperty
  a_erd: assert property (p_erd) else $error("refused read not zero");
  property p_syn; divider_sync |=> !divider_sync; endproperty
  a_syn: assert property (p_syn) else $error("sync too long");
  property p_gap; divider_sync |-> gap_reg >= 7'h4A; endproperty
  a_gap: assert property (p_gap) else $error("sync too close");
  property p_soft; soft_reset_active |=> !soft_reset_active [*8]; endproperty
  a_soft: assert property (p_soft) else $error("reset pulse");
  property p_rst;
    $rose(reset_n) |-> !divider_sync && !pready && !soft_reset_active;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs after reset");
  c_err: cover property (pslverr);
  c_sync: cover property (divider_sync);
  c_soft: cover property (soft_reset_active);
endmodule
bind sysref_request_window_sync sysref_req_checker i_chk (
  .mclk(mclk),
  .reset_n(reset_n),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .divider_sync(divider_sync),
  .soft_reset_active(soft_reset_active)
);

// [tb/sysref_req_partner.sv]
// partner: system controller driving the request pin and clock sample
module sysref_req_partner (
  // commands from the bench
  input wire logic mclk,
  input wire logic go,
  input wire logic [7:0] hi_cyc,
  input wire logic clk_lvl,
  // pins
  output logic request_input_pin,
  output logic input_clock_pin,
  output logic busy
);
  timeunit 1ns / 1ns;
  logic [7:0] left_reg = 8'h00;
  logic tgl_reg = 1'b0;
  always @(posedge mclk) begin
    tgl_reg <= !tgl_reg;
    if (go && !busy) left_reg <= hi_cyc;
    else if (busy) left_reg <= left_reg - 8'h01;
  end
  assign busy = left_reg != 8'h00;
  // pin always returns low, the level it starts from
  assign request_input_pin = busy;
  // clock phase fixed during a pulse; toggles outside so nothing is kind
  assign input_clock_pin = busy ? clk_lvl : tgl_reg;
endmodule

// [tb/tb_sysref_request_window_sync.sv]
// testbench: apb sequences with expected values for the request block
module tb_sysref_request_window_sync;
  timeunit 1ns / 1ns;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic go = 1'b0;
  logic clk_lvl = 1'b0;
  logic [7:0] hi_cyc = 8'h00;
  logic [31:0] prdata, request_delay_fs, rd;
  logic pready, pslverr, request_internal, frame_request, er;
  logic divider_sync, soft_reset_active;
  logic request_input_pin, input_clock_pin, busy;
  int fail_count = 0;
  int total_checks = 0;
  int syncs = 0;
  int softs = 0;
  int k;
  int stp [4] = '{sysref_req_pkg::step_fs_0, sysref_req_pkg::step_fs_1,
    sysref_req_pkg::step_fs_2, sysref_req_pkg::step_fs_3};
  sysref_request_window_sync #(.soft_reset_cycles(10)) i_dut (
    .mclk(mclk),
    .reset_n(reset_n),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .request_input_pin(request_input_pin),
    .input_clock_pin(input_clock_pin),
    .request_internal(request_internal),
    .frame_request(frame_request),
    .divider_sync(divider_sync),
    .soft_reset_active(soft_reset_active),
    .request_delay_fs(request_delay_fs)
  );
  sysref_req_partner i_far (
    .mclk(mclk),
    .go(go),
    .hi_cyc(hi_cyc),
    .clk_lvl(clk_lvl),
    .request_input_pin(request_input_pin),
    .input_clock_pin(input_clock_pin),
    .busy(busy)
  );
  initial forever #10 mclk = ~mclk;
  always @(posedge mclk) begin
    if (divider_sync === 1'b1) syncs++;
    if (soft_reset_active === 1'b1) softs++;
  end
  task automatic give_verdict();
    $display("checks %0d errors %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h want %h", $time, seen, exp);
    end
  endtask
  task automatic tmo(input logic hung);
    if (hung) begin
      fail_count++;
      $display("Error at %0t: wait ran out", $time);
      give_verdict();
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 20 && pready !== 1'b1; n++) @(posedge mclk);
    tmo(pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(rd & m, e);
  endtask
  task automatic pulse(input logic [7:0] n, input logic lvl);
    int i;
    @(posedge mclk);
    go <= 1'b1;
    hi_cyc <= n;
    clk_lvl <= lvl;
    @(posedge mclk);
    go <= 1'b0;
    @(posedge mclk);
    for (i = 0; i < 300 && busy !== 1'b0; i++) @(posedge mclk);
    tmo(busy !== 1'b0);
  endtask
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    rd_chk(sysref_req_pkg::ctrl_off, 32'hF, 32'h1);
    rd_chk(sysref_req_pkg::delay_off, 32'h37F, 32'h0);
    rd_chk(sysref_req_pkg::current_off, 32'hF, 32'h0);
    rd_chk(8'h14, 32'hFFFFFFFF, 32'h0);
    chk(er, 1'b1);
    for (k = 0; k < 4; k++) begin
      apb(1'b1, sysref_req_pkg::delay_off, {22'h0, k[1:0], 8'h7F});
      repeat (2) @(posedge mclk);
      chk(request_delay_fs, stp[k] * 127);
    end
    apb(1'b1, sysref_req_pkg::ctrl_off, 32'hD);
    repeat (2) @(posedge mclk);
    chk(request_internal, 1'b1);
    chk(frame_request, 1'b1);
    apb(1'b1, sysref_req_pkg::ctrl_off, 32'h9);
    repeat (2) @(posedge mclk);
    chk(request_internal, 1'b0);
    chk(frame_request, 1'b0);
    // too short a high time must not be reported as valid
    apb(1'b1, sysref_req_pkg::ctrl_off, 32'h2);
    pulse(8'h03, 1'b0);
    rd_chk(sysref_req_pkg::status_off, 32'h7, 32'h1);
    pulse(8'h08, 1'b1);
    rd_chk(sysref_req_pkg::status_off, 32'h7, 32'h7);
    // lowest working delay keeps drift over temperature small
    apb(1'b1, sysref_req_pkg::delay_off, 32'h0);
    repeat (2) @(posedge mclk);
    chk(request_delay_fs, 32'h0);
    apb(1'b1, sysref_req_pkg::ctrl_off, 32'h0);
    pulse(8'h08, 1'b0);
    repeat (20) @(posedge mclk);
    pulse(8'h08, 1'b0);
    repeat (80) @(posedge mclk);
    chk(syncs, 1);
    pulse(8'h08, 1'b0);
    repeat (80) @(posedge mclk);
    chk(syncs, 2);
    apb(1'b1, sysref_req_pkg::ctrl_off, 32'h10);
    repeat (5) @(posedge mclk);
    chk(syncs, 3);
    apb(1'b1, sysref_req_pkg::current_off, 32'h6);
    rd_chk(sysref_req_pkg::current_off, 32'hF, 32'h6);
    apb(1'b1, sysref_req_pkg::reset_off, 32'h1);
    apb(1'b1, sysref_req_pkg::reset_off, 32'h0);
    repeat (20) @(posedge mclk);
    chk(softs, 0);
    apb(1'b1, sysref_req_pkg::reset_off, 32'h1);
    repeat (12) @(posedge mclk);
    apb(1'b1, sysref_req_pkg::reset_off, 32'h0);
    repeat (20) @(posedge mclk);
    chk(softs, 1);
    rd_chk(sysref_req_pkg::current_off, 32'hF, 32'h0);
    rd_chk(sysref_req_pkg::ctrl_off, 32'hF, 32'h1);
    give_verdict();
  end
endmodule
